// ### inc/pin_select_pkg.sv
package pin_select_pkg;
   // Register map
   localparam logic [31:0] SEL_REG_ADDR      = 32'he002_c014;
   localparam int          ADDR_W            = 32;
   // Field positions
   localparam int          DEBUG_BIT         = 2;
   localparam int          TRACE_BIT         = 3;
   localparam int          BUS_LO            = 4;
   localparam int          ANALOG_IN6_BIT          = 6;
   localparam int          ANALOG_IN7_BIT          = 7;
   localparam int          WR_STB_BIT        = 8;
   localparam int          CS1_BIT           = 11;
   localparam int          CLKOUT_BIT        = 13;
   localparam int          CS2_LO            = 14;
   localparam int          CS3_LO            = 16;
   localparam int          ANALOG_IN4_BIT          = 21;
   localparam int          ANALOG_IN5_BIT          = 22;
   localparam int          ADDR0_BIT         = 23;
   localparam int          ADDR1_BIT         = 24;
   localparam int          ALINES_LO         = 25;
   // Writable bits; reserved bits read as zero
   localparam logic [31:0] SEL_WMASK         = 32'h0fe3_e9fc;
   // Field codes
   localparam logic [1:0]  BUS_8BIT          = 2'h0;
   localparam logic [1:0]  BUS_16BIT         = 2'h1;
   localparam logic [1:0]  BUS_32BIT         = 2'h2;
   localparam logic [1:0]  BUS_NONE          = 2'h3;
   localparam logic [1:0]  CS_ENABLE         = 2'h1;
   localparam logic [1:0]  BOOT_ALL_ONES     = 2'h3;
   localparam logic [1:0]  BOOT_ALL_ZERO     = 2'h0;
   localparam logic [2:0]  ALINES_NONE       = 3'h0;
   localparam logic [2:0]  ALINES_ALL        = 3'h7;
   // Bank decode (address bits 31:24)
   localparam logic [7:0]  BANK1_TOP         = 8'h81;
   localparam logic [7:0]  BANK2_TOP         = 8'h82;
   localparam logic [7:0]  BANK3_TOP         = 8'h83;
   localparam int          BANK_LO           = 24;
   // Fixed reset values
   localparam logic        AIN_RST           = 1'b1;
   // Start state
   localparam logic [31:0] RESET_PC          = 32'h0000_0000;
   // Pin ranges
   localparam int          DEBUG_PINS_LO     = 26;
   localparam int          TRACE_PINS_LO     = 16;
   localparam int          TRACE_PINS_HI     = 25;
   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_RUN   = 2'b01
   } boot_state_e;
endpackage

// ### core/sel_decode.sv
`timescale 1ns/10ps
// ----------------------------------------
// Address line span decode
// ----------------------------------------
module sel_decode
   import pin_select_pkg::*;
(
   input  wire logic [2:0]  alines_i,
   output logic      [23:0] addr_en_o
);
   function automatic logic [23:0] span(input logic [2:0] code);
      logic [23:0] m;
      m = 24'h00_0000;
      case (code)
         3'h1:    m = 24'h00_000c;
         3'h2:    m = 24'h00_003c;
         3'h3:    m = 24'h00_00fc;
         3'h4:    m = 24'h00_0ffc;
         3'h5:    m = 24'h00_fffc;
         3'h6:    m = 24'h0f_fffc;
         3'h7:    m = 24'hff_fffc;
         default: m = 24'h00_0000;
      endcase
      return m;
   endfunction
   always_comb begin
      addr_en_o = span(alines_i);
   end
endmodule

// ### core/bank_select.sv
`timescale 1ns/10ps
// ----------------------------------------
// Bank chip select decode
// ----------------------------------------
module bank_select
   import pin_select_pkg::*;
(
   input  wire logic [31:0] mem_addr_i,
   input  wire logic        mem_access_i,
   output logic      [3:1]  bank_cs_n_o
);
   always_comb begin
      bank_cs_n_o    = 3'h7;
      bank_cs_n_o[1] = !(mem_access_i && mem_addr_i[31:BANK_LO] == BANK1_TOP);
      bank_cs_n_o[2] = !(mem_access_i && mem_addr_i[31:BANK_LO] == BANK2_TOP);
      bank_cs_n_o[3] = !(mem_access_i && mem_addr_i[31:BANK_LO] == BANK3_TOP);
   end
endmodule

// ### core/memory_bus_pin_function_select.sv
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
module memory_bus_pin_function_select
   import pin_select_pkg::*;
(
   input  wire logic              core_clk_i,
   input  wire logic              resetn_i,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [31:0]       reg_wdata_i,
   input  wire logic              reg_write_i,
   input  wire logic              reg_read_i,
   output logic      [31:0]       reg_rdata_o,
   // Straps sampled on the first clock edge after reset release
   input  wire logic              returned_test_clock_i,
   input  wire logic              trace_sync_a_i,
   input  wire logic [1:0]        boot_config_pins_i,
   // GPIO direction from the GPIO block
   input  wire logic [31:0]       gpio_direction_p1_i,
   input  wire logic [31:0]       gpio_direction_p2_i,
   input  wire logic [31:0]       gpio_direction_p3_i,
   // Memory controller
   input  wire logic [31:0]       mem_addr_i,
   input  wire logic              mem_access_i,
   input  wire logic              mem_data_oe_i,
   input  wire logic              mem_wr_n_i,
   input  wire logic              mem_rd_n_i,
   input  wire logic              mem_cs0_n_i,
   input  wire logic [3:0]        mem_lane_n_i,
   // Resulting pin ownership and enables
   output logic      [31:0]       p1_is_gpio_o,
   output logic      [31:0]       p2_is_gpio_o,
   output logic      [31:0]       p3_is_gpio_o,
   output logic      [31:0]       p1_oe_o,
   output logic      [31:0]       p2_oe_o,
   output logic      [31:0]       p3_oe_o,
   output logic                   debug_port_en_o,
   output logic                   trace_port_en_o,
   output logic      [7:4]        analog_en_o,
   output logic                   clock_output_pin_en_o,
   output logic      [3:0]        chip_select_n_o,
   output logic                   write_strobe_n_o,
   output logic                   output_strobe_n_o,
   output logic      [3:0]        byte_lane_n_o,
   output logic      [31:0]       boot_pc_o
);
   // ----------------------------------------
   // Select register
   // ----------------------------------------
   logic [31:0]   sel_reg,   sel_next;
   logic [31:0]   rdata_reg, rdata_next;
   boot_state_e   st_reg,    st_next;
   logic [31:0]   strap_val;
   logic [31:0]   pc_reg,    pc_next;

   always_comb begin
      strap_val                      = 32'h0000_0000;
      strap_val[DEBUG_BIT]           = !returned_test_clock_i;
      strap_val[TRACE_BIT]           = trace_sync_a_i;
      strap_val[BUS_LO +: 2]         = boot_config_pins_i;
      strap_val[WR_STB_BIT]          = 1'b0;
      strap_val[CS1_BIT]             = 1'b0;
      strap_val[ANALOG_IN6_BIT]            = AIN_RST;
      strap_val[ANALOG_IN7_BIT]            = AIN_RST;
      strap_val[ANALOG_IN4_BIT]            = AIN_RST;
      strap_val[ANALOG_IN5_BIT]            = AIN_RST;
      strap_val[ADDR0_BIT]           = (boot_config_pins_i == BOOT_ALL_ZERO);
      strap_val[ADDR1_BIT]           = boot_config_pins_i[1];
      strap_val[ALINES_LO +: 3]      = (boot_config_pins_i == BOOT_ALL_ONES) ?
                                       ALINES_NONE : ALINES_ALL;
   end

   always_comb begin
      sel_next   = sel_reg;
      st_next    = st_reg;
      pc_next    = pc_reg;
      rdata_next = 32'h0000_0000;
      case (st_reg)
         ST_RESET: begin
            // Straps captured on the first clocked edge after release
            sel_next = strap_val & SEL_WMASK;
            st_next  = ST_RUN;
         end
         ST_RUN: begin
            if (reg_write_i && reg_addr_i == SEL_REG_ADDR) begin
               sel_next = reg_wdata_i & SEL_WMASK;
            end
         end
         default: st_next = ST_RESET;
      endcase
      if (reg_read_i && reg_addr_i == SEL_REG_ADDR) begin
         rdata_next = sel_reg & SEL_WMASK;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         sel_reg   <= 32'h0000_0000;
         st_reg    <= ST_RESET;
         rdata_reg <= 32'h0000_0000;
         pc_reg    <= RESET_PC;
      end else begin
         sel_reg   <= sel_next;
         st_reg    <= st_next;
         rdata_reg <= rdata_next;
         pc_reg    <= pc_next;
      end
   end

   assign reg_rdata_o = rdata_reg;
   assign boot_pc_o   = pc_reg;

   // ----------------------------------------
   // Decoders
   // ----------------------------------------
   logic [23:0] addr_en;
   logic [3:1]  bank_cs_n;
   logic [1:0]  bus_mode;
   logic        bus8, bus16, bus32;

   sel_decode u_sel_decode (
      .alines_i  (sel_reg[ALINES_LO +: 3]),
      .addr_en_o (addr_en)
   );

   bank_select u_bank_select (
      .mem_addr_i   (mem_addr_i),
      .mem_access_i (mem_access_i),
      .bank_cs_n_o  (bank_cs_n)
   );

   assign bus_mode = sel_reg[BUS_LO +: 2];
   assign bus8     = (bus_mode != BUS_NONE);
   assign bus16    = (bus_mode == BUS_16BIT) || (bus_mode == BUS_32BIT);
   assign bus32    = (bus_mode == BUS_32BIT);

   // ----------------------------------------
   // Pin ownership
   // ----------------------------------------
   logic [31:0] p1_per, p2_per, p3_per;
   logic        in_run;

   assign in_run = (st_reg == ST_RUN);

   always_comb begin
      p1_per = 32'h0000_0000;
      p2_per = 32'h0000_0000;
      p3_per = 32'h0000_0000;
      if (in_run) begin
         p1_per[31:DEBUG_PINS_LO]         = {6{sel_reg[DEBUG_BIT]}};
         p1_per[TRACE_PINS_HI:TRACE_PINS_LO] = {10{sel_reg[TRACE_BIT]}};
         p2_per[7:0]   = {8{bus8}};
         p1_per[0]     = bus8;
         p1_per[1]     = bus8;
         p3_per[31]    = bus8;
         p2_per[15:8]  = {8{bus16}};
         p3_per[30]    = bus16;
         p2_per[31:16] = {16{bus32}};
         p3_per[29]    = bus32 || sel_reg[ANALOG_IN6_BIT];
         p3_per[28]    = bus32 || sel_reg[ANALOG_IN7_BIT];
         p2_per[30]    = bus32 || sel_reg[ANALOG_IN4_BIT];
         p2_per[31]    = bus32 || sel_reg[ANALOG_IN5_BIT];
         p3_per[27]    = sel_reg[WR_STB_BIT];
         p3_per[26]    = sel_reg[CS1_BIT];
         p3_per[25]    = (sel_reg[CS2_LO +: 2] == CS_ENABLE);
         p3_per[24]    = (sel_reg[CS3_LO +: 2] == CS_ENABLE);
         p3_per[23:0]  = addr_en;
         p3_per[23]    = addr_en[23] || sel_reg[CLKOUT_BIT];
         p3_per[0]     = sel_reg[ADDR0_BIT];
         p3_per[1]     = sel_reg[ADDR1_BIT];
      end
   end

   assign p1_is_gpio_o = ~p1_per;
   assign p2_is_gpio_o = ~p2_per;
   assign p3_is_gpio_o = ~p3_per;

   // Direction: GPIO bits only on GPIO pins, inputs after reset
   assign p1_oe_o = in_run ? ((gpio_direction_p1_i & ~p1_per) | (p1_per & 32'h0000_0003))
                           : 32'h0000_0000;
   assign p2_oe_o = in_run ? ((gpio_direction_p2_i & ~p2_per)
                              | (p2_per & ~{analog_en_o[5], analog_en_o[4], 30'h0000_0000}
                                 & {32{mem_data_oe_i}})) : 32'h0000_0000;
   assign p3_oe_o = in_run ? ((gpio_direction_p3_i & ~p3_per)
                              | (p3_per & ~{2'b00, sel_reg[ANALOG_IN6_BIT] & ~bus32,
                                 sel_reg[ANALOG_IN7_BIT] & ~bus32, 28'h000_0000}))
                           : 32'h0000_0000;

   // ----------------------------------------
   // Peripheral signals onto pins
   // ----------------------------------------
   assign debug_port_en_o       = in_run && sel_reg[DEBUG_BIT];
   assign trace_port_en_o       = in_run && sel_reg[TRACE_BIT];
   assign analog_en_o[4]        = in_run && !bus32 && sel_reg[ANALOG_IN4_BIT];
   assign analog_en_o[5]        = in_run && !bus32 && sel_reg[ANALOG_IN5_BIT];
   assign analog_en_o[6]        = in_run && !bus32 && sel_reg[ANALOG_IN6_BIT];
   assign analog_en_o[7]        = in_run && !bus32 && sel_reg[ANALOG_IN7_BIT];
   assign clock_output_pin_en_o = in_run && sel_reg[CLKOUT_BIT]
                                  && (sel_reg[ALINES_LO +: 3] != ALINES_ALL);

   // Inactive strobes stay high when the function is off
   assign chip_select_n_o[0] = !(p1_per[0]) || mem_cs0_n_i;
   assign chip_select_n_o[1] = !(p3_per[26]) || bank_cs_n[1];
   assign chip_select_n_o[2] = !(p3_per[25]) || bank_cs_n[2];
   assign chip_select_n_o[3] = !(p3_per[24]) || bank_cs_n[3];
   assign write_strobe_n_o   = !(p3_per[27]) || mem_wr_n_i;
   assign output_strobe_n_o  = !(p1_per[1]) || mem_rd_n_i;
   assign byte_lane_n_o[0]   = !(p3_per[31]) || mem_lane_n_i[0];
   assign byte_lane_n_o[1]   = !(p3_per[30]) || mem_lane_n_i[1];
   assign byte_lane_n_o[2]   = !(bus32) || !in_run || mem_lane_n_i[2];
   assign byte_lane_n_o[3]   = !(bus32) || !in_run || mem_lane_n_i[3];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_RESERVED_ZERO: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      (reg_rdata_o & ~SEL_WMASK) == 32'h0000_0000)
      else $error("reserved bits read nonzero");
   AST_READ_LATENCY: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      reg_read_i && reg_addr_i == SEL_REG_ADDR |=> reg_rdata_o == ($past(sel_reg) & SEL_WMASK))
      else $error("read data wrong");
   AST_BOOT_ALINES: assert property (@(posedge core_clk_i)
      $rose(resetn_i) |=> sel_reg[ALINES_LO +: 3] ==
         (($past(boot_config_pins_i) == BOOT_ALL_ONES) ? ALINES_NONE : ALINES_ALL))
      else $error("address field strap wrong");
   AST_BOOT_A1: assert property (@(posedge core_clk_i)
      $rose(resetn_i) |=> sel_reg[ADDR1_BIT] == $past(boot_config_pins_i[1]))
      else $error("address 1 strap wrong");
   AST_DEBUG_STRAP: assert property (@(posedge core_clk_i)
      $rose(resetn_i) |=> sel_reg[DEBUG_BIT] == !$past(returned_test_clock_i))
      else $error("debug strap wrong");
   AST_CS1_BANK: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      !chip_select_n_o[1] |-> mem_addr_i[31:BANK_LO] == BANK1_TOP)
      else $error("cs1 outside bank");
   AST_GPIO_INPUT: assert property (@(posedge core_clk_i)
      !resetn_i |=> p1_oe_o == 32'h0000_0000 && p3_oe_o == 32'h0000_0000)
      else $error("gpio driving after reset");
   AST_WIDE_BUS: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      in_run && bus_mode == BUS_32BIT |-> !p2_is_gpio_o[31] && analog_en_o == 4'h0)
      else $error("wide bus ownership wrong");
   AST_NARROW_BUS: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      in_run && bus_mode == BUS_8BIT |-> p2_is_gpio_o[15:8] == 8'hff && byte_lane_n_o[1])
      else $error("narrow bus ownership wrong");
   AST_NO_BUS: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      bus_mode == BUS_NONE |-> p2_is_gpio_o[7:0] == 8'hff && chip_select_n_o[0]
         && output_strobe_n_o && byte_lane_n_o[0])
      else $error("data pins taken with bus off");
   AST_BYTE_BUS: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      in_run && bus_mode != BUS_NONE |-> p2_is_gpio_o[7:0] == 8'h00
         && !p1_is_gpio_o[0] && !p1_is_gpio_o[1] && !p3_is_gpio_o[31])
      else $error("low data pins not given to bus");
   AST_HALF_BUS: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      in_run && bus_mode == BUS_16BIT |-> p2_is_gpio_o[15:8] == 8'h00
         && !p3_is_gpio_o[30] && p2_is_gpio_o[29:16] == 14'h3fff)
      else $error("half bus ownership wrong");
   AST_ANALOG_UNDRIVEN: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      !(analog_en_o[4] && p2_oe_o[30]) && !(analog_en_o[5] && p2_oe_o[31])
         && !(analog_en_o[6] && p3_oe_o[29]) && !(analog_en_o[7] && p3_oe_o[28]))
      else $error("analog pin driven");
   AST_WE_OFF: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      !sel_reg[WR_STB_BIT] |-> write_strobe_n_o && p3_is_gpio_o[27])
      else $error("write strobe active while off");
   AST_CS1_OFF: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      !sel_reg[CS1_BIT] |-> chip_select_n_o[1] && p3_is_gpio_o[26])
      else $error("cs1 active while off");
   AST_CS2_OFF: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      sel_reg[CS2_LO +: 2] != CS_ENABLE |-> chip_select_n_o[2] && p3_is_gpio_o[25])
      else $error("cs2 active while off");
   AST_CS3_OFF: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      sel_reg[CS3_LO +: 2] != CS_ENABLE |-> chip_select_n_o[3] && p3_is_gpio_o[24])
      else $error("cs3 active while off");
   AST_CLKOUT_FULL: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      sel_reg[ALINES_LO +: 3] == ALINES_ALL |-> !clock_output_pin_en_o && !p3_is_gpio_o[23])
      else $error("clock output with full address");
   AST_ADDR_NONE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      in_run && sel_reg[ALINES_LO +: 3] == ALINES_NONE |-> p3_is_gpio_o[22:2] == 21'h1f_ffff)
      else $error("address lines on with none selected");
   AST_ADDR_ALL: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      in_run && sel_reg[ALINES_LO +: 3] == ALINES_ALL |-> p3_is_gpio_o[22:2] == 21'h00_0000)
      else $error("address lines off with all selected");
   AST_BOOT_A0: assert property (@(posedge core_clk_i)
      $rose(resetn_i) |=> sel_reg[ADDR0_BIT] == ($past(boot_config_pins_i) == BOOT_ALL_ZERO))
      else $error("address 0 strap wrong");
   AST_TRACE_STRAP: assert property (@(posedge core_clk_i)
      $rose(resetn_i) |=> sel_reg[TRACE_BIT] == $past(trace_sync_a_i))
      else $error("trace strap wrong");
   AST_GPIO_DIR: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      in_run |-> (p1_oe_o & p1_is_gpio_o) == (gpio_direction_p1_i & p1_is_gpio_o)
         && (p3_oe_o & p3_is_gpio_o) == (gpio_direction_p3_i & p3_is_gpio_o))
      else $error("gpio direction ignored");
   AST_WIDE_LANES_OFF: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
      !bus32 |-> byte_lane_n_o[3:2] == 2'h3)
      else $error("upper lanes active on narrow bus");
endmodule

// ### verif/memory_bus_pin_function_select_tb.sv
`timescale 1ns/10ps
module memory_bus_pin_function_select_tb
   import pin_select_pkg::*;
();
   logic              core_clk_i;
   logic              resetn_i;
   logic [ADDR_W-1:0] reg_addr_i;
   logic [31:0]       reg_wdata_i;
   logic              reg_write_i;
   logic              reg_read_i;
   logic [31:0]       reg_rdata_o;
   logic              returned_test_clock_i;
   logic              trace_sync_a_i;
   logic [1:0]        boot_config_pins_i;
   logic [31:0]       gpio_direction_p1_i;
   logic [31:0]       gpio_direction_p2_i;
   logic [31:0]       gpio_direction_p3_i;
   logic [31:0]       mem_addr_i;
   logic              mem_access_i;
   logic              mem_data_oe_i;
   logic              mem_wr_n_i;
   logic              mem_rd_n_i;
   logic              mem_cs0_n_i;
   logic [3:0]        mem_lane_n_i;
   logic [31:0]       p1_is_gpio_o;
   logic [31:0]       p2_is_gpio_o;
   logic [31:0]       p3_is_gpio_o;
   logic [31:0]       p1_oe_o;
   logic [31:0]       p2_oe_o;
   logic [31:0]       p3_oe_o;
   logic              debug_port_en_o;
   logic              trace_port_en_o;
   logic [7:4]        analog_en_o;
   logic              clock_output_pin_en_o;
   logic [3:0]        chip_select_n_o;
   logic              write_strobe_n_o;
   logic              output_strobe_n_o;
   logic [3:0]        byte_lane_n_o;
   logic [31:0]       boot_pc_o;
   logic [31:0]       rd;
   logic [31:0]       v;
   logic [31:0]       m;
   logic [31:0]       e;
   int                err_count   = 0;
   int                num_checks  = 0;
   int                cycle_count = 0;
   logic [31:0]       cs_addr [6] = '{32'h8100_0000, 32'h81ff_ffff, 32'h8200_0000,
                                      32'h83ff_ffff, 32'h8400_0000, 32'h80ff_ffff};
   logic [2:0]        cs_exp [6]  = '{3'b110, 3'b110, 3'b101, 3'b011, 3'b111, 3'b111};
   int                tops [8]    = '{1, 3, 5, 7, 11, 15, 19, 23};

   memory_bus_pin_function_select dut_u (
      .core_clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i,
      .reg_rdata_o, .returned_test_clock_i, .trace_sync_a_i, .boot_config_pins_i,
      .gpio_direction_p1_i, .gpio_direction_p2_i, .gpio_direction_p3_i,
      .mem_addr_i, .mem_access_i, .mem_data_oe_i, .mem_wr_n_i, .mem_rd_n_i,
      .mem_cs0_n_i, .mem_lane_n_i, .p1_is_gpio_o, .p2_is_gpio_o, .p3_is_gpio_o,
      .p1_oe_o, .p2_oe_o, .p3_oe_o, .debug_port_en_o, .trace_port_en_o, .analog_en_o,
      .clock_output_pin_en_o, .chip_select_n_o, .write_strobe_n_o, .output_strobe_n_o,
      .byte_lane_n_o, .boot_pc_o
   );

   always #4 core_clk_i = ~core_clk_i;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge core_clk_i) begin
      cycle_count <= cycle_count + 1;
      if (cycle_count == 3000) begin
         err_count++;
         report_and_stop();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      reg_write_i <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      reg_write_i <= 1'b0;
      #1;
   endtask

   task automatic reg_rd(input logic [31:0] a);
      @(posedge core_clk_i);
      reg_read_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_read_i <= 1'b0;
      #1;
      rd = reg_rdata_o;
   endtask

   task automatic drive_mem(input logic [31:0] a, input logic acc);
      @(posedge core_clk_i);
      mem_addr_i   <= a;
      mem_access_i <= acc;
      #1;
   endtask

   task automatic drive_p2(input logic oe, input logic [31:0] dir);
      @(posedge core_clk_i);
      mem_data_oe_i       <= oe;
      gpio_direction_p2_i <= dir;
      #1;
   endtask

   // Straps: bit 0 feeds test clock pin, bit 1 the sync pin
   task automatic do_reset(input logic [1:0] b);
      @(posedge core_clk_i);
      resetn_i              <= 1'b0;
      boot_config_pins_i    <= b;
      returned_test_clock_i <= b[0];
      trace_sync_a_i        <= b[1];
      gpio_direction_p1_i   <= 32'hffff_ffff;
      gpio_direction_p2_i   <= 32'hffff_ffff;
      gpio_direction_p3_i   <= 32'hffff_ffff;
      repeat (10) @(posedge core_clk_i);
      #1;
      chk("oe_in_reset", p1_oe_o | p2_oe_o | p3_oe_o, 32'h0000_0000);
      @(posedge core_clk_i);
      resetn_i            <= 1'b1;
      gpio_direction_p1_i <= 32'h0000_0000;
      gpio_direction_p2_i <= 32'h0000_0000;
      gpio_direction_p3_i <= 32'h0000_0000;
      @(posedge core_clk_i);
   endtask

   function automatic logic [31:0] rst_exp(input logic [1:0] bb);
      logic [31:0] r;
      r        = 32'h0060_00c0;
      r[2]     = ~bb[0];
      r[3]     = bb[1];
      r[5:4]   = bb;
      r[23]    = (bb == 2'b00);
      r[24]    = bb[1];
      r[27:25] = (bb == 2'b11) ? 3'h0 : 3'h7;
      return r;
   endfunction

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      core_clk_i = 1'b0; resetn_i = 1'b0; reg_addr_i = '0; reg_wdata_i = '0;
      reg_write_i = 1'b0; reg_read_i = 1'b0; returned_test_clock_i = 1'b1;
      trace_sync_a_i = 1'b0; boot_config_pins_i = 2'h0; gpio_direction_p1_i = '0;
      gpio_direction_p2_i = '0; gpio_direction_p3_i = '0; mem_addr_i = '0;
      mem_access_i = 1'b0; mem_data_oe_i = 1'b0; mem_wr_n_i = 1'b0; mem_rd_n_i = 1'b0;
      mem_cs0_n_i = 1'b0; mem_lane_n_i = 4'h0;
      for (int b = 0; b < 4; b++) begin
         do_reset(b[1:0]);
         reg_rd(SEL_REG_ADDR);
         chk("reset_value", rd, rst_exp(b[1:0]));
         chk("debug_en", {31'h0, debug_port_en_o}, {31'h0, ~b[0]});
         chk("trace_en", {31'h0, trace_port_en_o}, {31'h0, b[1]});
         chk("boot_pc", boot_pc_o, 32'h0000_0000);
      end
      $display("test reset_straps done");
      reg_wr(SEL_REG_ADDR, 32'hffff_ffff);
      reg_rd(SEL_REG_ADDR);
      chk("write_mask", rd, 32'h0fe3_e9fc);
      reg_wr(SEL_REG_ADDR + 32'h0000_0004, 32'h0000_0000);
      reg_rd(SEL_REG_ADDR);
      chk("unmapped_write", rd, 32'h0fe3_e9fc);
      reg_rd(SEL_REG_ADDR + 32'h0000_0004);
      chk("unmapped_read", rd, 32'h0000_0000);
      $display("test register_access done");
      for (int c = 0; c < 4; c++) begin
         v      = 32'h0060_00c0;
         v[5:4] = c[1:0];
         m = (c == 3) ? 32'h0 : (c == 0) ? 32'hff : (c == 1) ? 32'hffff : 32'hffff_ffff;
         drive_p2(1'b1, 32'h0000_0000);
         reg_wr(SEL_REG_ADDR, v);
         chk("p2_gpio", p2_is_gpio_o & 32'h3fff_ffff, ~m & 32'h3fff_ffff);
         chk("p1_gpio", {30'h0, p1_is_gpio_o[1:0]}, (c == 3) ? 32'h3 : 32'h0);
         chk("analog", {28'h0, analog_en_o}, (c == 2) ? 32'h0 : 32'hf);
         chk("lanes", {28'h0, byte_lane_n_o},
             {28'h0, ~{c == 2, c == 2, c == 1 || c == 2, c != 3}});
         chk("strobes", {30'h0, output_strobe_n_o, chip_select_n_o[0]},
             (c == 3) ? 32'h3 : 32'h0);
         chk("p2_oe_bus", p2_oe_o, m);
         drive_p2(1'b0, 32'hffff_ffff);
         chk("p2_oe_gpio", p2_oe_o, ~m & 32'h3fff_ffff);
      end
      $display("test data_bus done");
      reg_wr(SEL_REG_ADDR, 32'h0061_49c0);
      chk("p3_gpio_cs", {26'h0, p3_is_gpio_o[27:24], p3_is_gpio_o[1:0]}, 32'h3);
      chk("wr_strobe", {31'h0, write_strobe_n_o}, 32'h0);
      for (int i = 0; i < 6; i++) begin
         drive_mem(cs_addr[i], 1'b1);
         chk("bank_cs", {29'h0, chip_select_n_o[3:1]}, {29'h0, cs_exp[i]});
      end
      drive_mem(32'h8100_0000, 1'b0);
      chk("bank_cs_idle", {29'h0, chip_select_n_o[3:1]}, 32'h7);
      reg_wr(SEL_REG_ADDR, 32'h0061_88c0);
      drive_mem(32'h8200_0000, 1'b1);
      chk("cs2_reserved", {29'h0, chip_select_n_o[3:1]}, 32'h7);
      chk("p3_gpio_res", {28'h0, p3_is_gpio_o[27:24]}, 32'ha);
      chk("wr_strobe_off", {31'h0, write_strobe_n_o}, 32'h1);
      $display("test chip_selects done");
      for (int k = 0; k < 8; k++) begin
         v        = 32'h01e0_20c0;
         v[27:25] = k[2:0];
         reg_wr(SEL_REG_ADDR, v);
         e = 32'hffff_fffc;
         for (int i = 2; i <= tops[k]; i++) begin
            e[i] = 1'b0;
         end
         chk("addr_lines", p3_is_gpio_o & 32'h007f_ffff, e & 32'h007f_ffff);
         chk("clk_out", {31'h0, clock_output_pin_en_o}, {31'h0, k != 7});
         chk("addr_oe", {30'h0, p3_oe_o[1:0]}, 32'h3);
      end
      $display("test address_lines done");
      report_and_stop();
   end
endmodule
